/* File: hw/pcsr_params.svh */
// Constants of the protection configuration and status register bank.
// Assumes byte-wide registers behind the serial programming port.
`ifndef PCSR_PARAMS_SVH
`define PCSR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PCSR_OFS_ABS_OV    8'h25
`define PCSR_OFS_REL_OV    8'h26
`define PCSR_OFS_UV        8'h27
`define PCSR_OFS_OT        8'h28
`define PCSR_OFS_DISABLE   8'h29
`define PCSR_OFS_FAULT     8'h2a
`define PCSR_OFS_PHASE_OC  8'h2b
`define PCSR_OFS_GAIN      8'h2c

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCSR_RST_ABS_OV    2'h0
`define PCSR_RST_REL_OV    2'h0
`define PCSR_RST_UV        2'h0
`define PCSR_RST_OT        2'h0
`define PCSR_RST_DISABLE   5'h00
`define PCSR_RST_FAULT     5'h00
`define PCSR_RST_PHASE_OC  8'h00
`define PCSR_RST_GAIN      2'h2

// ----------------------------------------------------------------------
// Write lock key and field positions
// ----------------------------------------------------------------------
`define PCSR_LOCK_KEY      8'ha6
`define PCSR_BIT_OV        0
`define PCSR_BIT_UV        1
`define PCSR_BIT_SUM_OC    2
`define PCSR_BIT_INT_OT    3
`define PCSR_BIT_MON_OT    4
`define PCSR_NUM_FAULTS    5
`define PCSR_NUM_PHASES    8

`endif

/* File: hw/pcsr_pkg.sv */
// Types shared by the protection configuration and status register bank.
// Assumes the constants header is included where numbers are needed.
`default_nettype none

package pcsr_pkg;
  typedef logic [1:0] pcsr_code_t;
  typedef logic [7:0] pcsr_byte_t;
  typedef logic [4:0] pcsr_fault_t;
  typedef logic [7:0] pcsr_phase_t;
endpackage

`default_nettype wire

/* File: hw/pcsr_sync.sv */
// Two-flop synchroniser, one stage pair per bit.
// Assumes the inputs come from analogue detectors outside sys_clk.
`default_nettype none

module pcsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  // --------------------------------------------------------------------
  // Per-bit stages
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q     <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          meta_q     <= asyncIn[i];
          syncOut[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/pcsr_regs.sv */
// Protection threshold, disable, trip flag and amplifier gain registers.
// Assumes a serial port engine on sys_clk that presents byte accesses,
// and the key register and reporting enable supplied from elsewhere.
`include "pcsr_params.svh"
`default_nettype none

module pcsr_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire pcsr_pkg::pcsr_byte_t regAddr,
  input  wire logic                 regWrEn,
  input  wire pcsr_pkg::pcsr_byte_t regWrData,
  output var  pcsr_pkg::pcsr_byte_t regRdData,
  input  wire pcsr_pkg::pcsr_byte_t keyValue,
  input  wire logic                 phaseReportEn,
  input  wire pcsr_pkg::pcsr_fault_t faultDetect,
  input  wire pcsr_pkg::pcsr_phase_t phaseOcDetect,
  output var  pcsr_pkg::pcsr_code_t absOvCode,
  output var  pcsr_pkg::pcsr_code_t relOvCode,
  output var  pcsr_pkg::pcsr_code_t uvCode,
  output var  pcsr_pkg::pcsr_code_t otCode,
  output var  pcsr_pkg::pcsr_fault_t protDisable,
  output var  pcsr_pkg::pcsr_code_t gainCode,
  output var  pcsr_pkg::pcsr_fault_t faultFlags,
  output var  pcsr_pkg::pcsr_phase_t phaseOcFlags
);
  import pcsr_pkg::*;

  // --------------------------------------------------------------------
  // Detector inputs into the clock domain
  // --------------------------------------------------------------------
  pcsr_fault_t faultSync;
  pcsr_phase_t phaseSync;

  pcsr_sync #(.WIDTH(`PCSR_NUM_FAULTS)) uFaultSync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .asyncIn (faultDetect),
    .syncOut (faultSync)
  );

  pcsr_sync #(.WIDTH(`PCSR_NUM_PHASES)) uPhaseSync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .asyncIn (phaseOcDetect),
    .syncOut (phaseSync)
  );

  // --------------------------------------------------------------------
  // Address decode and write lock
  // --------------------------------------------------------------------
  wire logic wrOpen    = (keyValue != `PCSR_LOCK_KEY);
  wire logic wrOk      = regWrEn && wrOpen;
  wire logic selAbsOv  = (regAddr == `PCSR_OFS_ABS_OV);
  wire logic selRelOv  = (regAddr == `PCSR_OFS_REL_OV);
  wire logic selUv     = (regAddr == `PCSR_OFS_UV);
  wire logic selOt     = (regAddr == `PCSR_OFS_OT);
  wire logic selDis    = (regAddr == `PCSR_OFS_DISABLE);
  wire logic selFault  = (regAddr == `PCSR_OFS_FAULT);
  wire logic selPhase  = (regAddr == `PCSR_OFS_PHASE_OC);
  wire logic selGain   = (regAddr == `PCSR_OFS_GAIN);

  wire pcsr_code_t  wrCode  = regWrData[1:0];
  wire pcsr_fault_t wrBits5 = regWrData[4:0];

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  pcsr_code_t  absOv_q;
  pcsr_code_t  relOv_q;
  pcsr_code_t  uv_q;
  pcsr_code_t  ot_q;
  pcsr_fault_t dis_q;
  pcsr_code_t  gain_q;

  wire pcsr_code_t  absOv_d = (wrOk && selAbsOv) ? wrCode : absOv_q;
  wire pcsr_code_t  relOv_d = (wrOk && selRelOv) ? wrCode : relOv_q;
  wire pcsr_code_t  uv_d    = (wrOk && selUv)    ? wrCode : uv_q;
  wire pcsr_code_t  ot_d    = (wrOk && selOt)    ? wrCode : ot_q;
  wire pcsr_fault_t dis_d   = (wrOk && selDis)   ? wrBits5 : dis_q;
  wire pcsr_code_t  gain_d  = (wrOk && selGain)  ? wrCode : gain_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      absOv_q <= `PCSR_RST_ABS_OV;
      relOv_q <= `PCSR_RST_REL_OV;
      uv_q    <= `PCSR_RST_UV;
      ot_q    <= `PCSR_RST_OT;
      dis_q   <= `PCSR_RST_DISABLE;
      gain_q  <= `PCSR_RST_GAIN;
    end else begin
      absOv_q <= absOv_d;
      relOv_q <= relOv_d;
      uv_q    <= uv_d;
      ot_q    <= ot_d;
      dis_q   <= dis_d;
      gain_q  <= gain_d;
    end
  end

  assign absOvCode   = absOv_q;
  assign relOvCode   = relOv_q;
  assign uvCode      = uv_q;
  assign otCode      = ot_q;
  assign protDisable = dis_q;
  assign gainCode    = gain_q;

  // --------------------------------------------------------------------
  // Trip flags, never written by the host; fault flags sticky until reset, phase flags until reporting is turned off
  // --------------------------------------------------------------------
  pcsr_fault_t fault_q;
  pcsr_phase_t phase_q;

  // A disabled protection cannot trip
  wire pcsr_fault_t fault_d = fault_q | (faultSync & ~dis_q);
  // Reporting off holds the whole register at zero
  wire pcsr_phase_t phase_d =
    phaseReportEn ? (phase_q | phaseSync) : `PCSR_RST_PHASE_OC;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= `PCSR_RST_FAULT;
      phase_q <= `PCSR_RST_PHASE_OC;
    end else begin
      fault_q <= fault_d;
      phase_q <= phase_d;
    end
  end

  assign faultFlags   = fault_q;
  assign phaseOcFlags = phase_q;

  // --------------------------------------------------------------------
  // Read data, one cycle after the address
  // --------------------------------------------------------------------
  pcsr_byte_t rd_q;
  pcsr_byte_t rd_d;

  always_comb begin
    rd_d = 8'h00;
    if (selAbsOv) begin
      rd_d = {6'h00, absOv_q};
    end
    if (selRelOv) begin
      rd_d = {6'h00, relOv_q};
    end
    if (selUv) begin
      rd_d = {6'h00, uv_q};
    end
    if (selOt) begin
      rd_d = {6'h00, ot_q};
    end
    if (selDis) begin
      rd_d = {3'h0, dis_q};
    end
    if (selFault) begin
      rd_d = {3'h0, fault_q};
    end
    if (selPhase) begin
      rd_d = phase_q;
    end
    if (selGain) begin
      rd_d = {6'h00, gain_q};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_abs_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (regWrEn && selAbsOv && wrOpen) |=> (absOvCode == $past(regWrData[1:0]));
  endproperty
  a_abs_write: assert property (p_abs_write)
    else $error("absolute overvoltage code not written");

  property p_lock_holds;
    @(posedge sys_clk) disable iff (!rst_b)
    (regWrEn && !wrOpen) |=> ($stable(absOvCode) && $stable(relOvCode)
      && $stable(uvCode) && $stable(otCode) && $stable(gainCode)
      && $stable(protDisable));
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("locked write changed a setting");

  property p_rel_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (regWrEn && selRelOv && wrOpen) |=> (relOvCode == $past(regWrData[1:0]));
  endproperty
  a_rel_write: assert property (p_rel_write)
    else $error("relative overvoltage code not written");

  property p_uv_ot_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (regWrEn && wrOpen && (selUv || selOt)) |=>
      ((!$past(selUv) || (uvCode == $past(regWrData[1:0])))
      && (!$past(selOt) || (otCode == $past(regWrData[1:0]))));
  endproperty
  a_uv_ot_write: assert property (p_uv_ot_write)
    else $error("threshold code not written");

  property p_disabled_no_trip;
    @(posedge sys_clk) disable iff (!rst_b)
    ((faultFlags & protDisable) == 5'h00) ##1 ($stable(protDisable))
      |-> ((faultFlags & protDisable) == 5'h00);
  endproperty
  a_disabled_no_trip: assert property (p_disabled_no_trip)
    else $error("disabled protection tripped");

  property p_fault_sticky;
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 (($past(faultFlags) & ~faultFlags) == 5'h00);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault flag dropped");

  property p_phase_set;
    @(posedge sys_clk) disable iff (!rst_b)
    (phaseReportEn && phaseSync != 8'h00) |=>
      ((phaseOcFlags & $past(phaseSync)) == $past(phaseSync));
  endproperty
  a_phase_set: assert property (p_phase_set)
    else $error("phase trip not flagged");

  property p_phase_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    !phaseReportEn |=> (phaseOcFlags == 8'h00);
  endproperty
  a_phase_zero: assert property (p_phase_zero)
    else $error("phase flags set while reporting off");

  property p_gain_write;
    @(posedge sys_clk) disable iff (!rst_b)
    (regWrEn && selGain && wrOpen) |=> (gainCode == $past(regWrData[1:0]));
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain code not written");

  property p_rd_upper_zero;
    @(posedge sys_clk) disable iff (!rst_b)
    (selAbsOv || selGain) |=> (regRdData[7:2] == 6'h00);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero)
    else $error("upper read bits not zero");

  c_locked_write: cover property (@(posedge sys_clk) disable iff (!rst_b)
    regWrEn && !wrOpen);
  c_open_write: cover property (@(posedge sys_clk) disable iff (!rst_b)
    regWrEn && wrOpen && selGain);
  c_fault_trip: cover property (@(posedge sys_clk) disable iff (!rst_b)
    faultFlags != 5'h00);
  c_phase_trip: cover property (@(posedge sys_clk) disable iff (!rst_b)
    phaseOcFlags != 8'h00);

endmodule

`default_nettype wire

/* File: testbench/pcsr_host_model.sv */
// Host model for the register port: byte writes and reads.
// Assumes the bank samples its port on the rising edge of sys_clk.
`default_nettype none

module pcsr_host_model (
  input  wire logic                 sys_clk,
  output var  pcsr_pkg::pcsr_byte_t regAddr,
  output var  logic                 regWrEn,
  output var  pcsr_pkg::pcsr_byte_t regWrData,
  input  wire pcsr_pkg::pcsr_byte_t regRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcsr_pkg::*;

  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
  end

  // One-cycle strobe; data line does not hold its value afterwards
  task automatic wr(input pcsr_byte_t a, input pcsr_byte_t d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask

  // Read data is registered one edge after the address
  task automatic rd(input pcsr_byte_t a, output pcsr_byte_t d);
    @(posedge sys_clk);
    regAddr <= a;
    @(posedge sys_clk);
    #1;
    d = regRdData;
  endtask
endmodule

`default_nettype wire

/* File: testbench/protection_config_status_regs_tb.sv */
// Self-checking bench for the protection register bank.
// Assumes pcsr_regs and the host model are compiled beforehand.
`default_nettype none

module protection_config_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcsr_pkg::*;

  logic        sys_clk;
  logic        rst_b;
  logic        regWrEn;
  logic        phaseReportEn;
  pcsr_byte_t  regAddr;
  pcsr_byte_t  regWrData;
  pcsr_byte_t  regRdData;
  pcsr_byte_t  keyValue;
  pcsr_fault_t faultDetect;
  pcsr_fault_t protDisable;
  pcsr_fault_t faultFlags;
  pcsr_phase_t phaseOcDetect;
  pcsr_phase_t phaseOcFlags;
  pcsr_code_t  absOvCode;
  pcsr_code_t  relOvCode;
  pcsr_code_t  uvCode;
  pcsr_code_t  otCode;
  pcsr_code_t  gainCode;
  int          num_errors;
  int          samples_checked;
  int          seed;
  int          cyc;
  pcsr_byte_t  mdl [0:7];
  pcsr_fault_t mf;
  pcsr_phase_t mp;

  pcsr_regs i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .keyValue(keyValue), .phaseReportEn(phaseReportEn),
    .faultDetect(faultDetect), .phaseOcDetect(phaseOcDetect),
    .absOvCode(absOvCode), .relOvCode(relOvCode), .uvCode(uvCode),
    .otCode(otCode), .protDisable(protDisable), .gainCode(gainCode),
    .faultFlags(faultFlags), .phaseOcFlags(phaseOcFlags));

  pcsr_host_model i_host (.sys_clk(sys_clk), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData));

  always #50 sys_clk = ~sys_clk;

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string n, input pcsr_byte_t e,
                     input pcsr_byte_t g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  function automatic pcsr_byte_t expRd(input int a);
    if (a == 'h2a) return 8'(mf);
    if (a == 'h2b) return mp;
    if (a >= 'h25 && a <= 'h2c) return mdl[a - 'h25];
    return 8'h00;
  endfunction

  // Host write plus the reference model of the write lock
  task automatic wrM(input int a, input pcsr_byte_t d);
    i_host.wr(8'(a), d);
    if (keyValue != 8'ha6 && a >= 'h25 && a <= 'h2c)
      if (a != 'h2a && a != 'h2b)
        mdl[a - 'h25] = d & ((a == 'h29) ? 8'h1f : 8'h03);
  endtask

  task automatic chkAll;
    pcsr_byte_t v;
    for (int a = 'h25; a <= 'h2d; a++) begin
      i_host.rd(8'(a), v);
      chk($sformatf("reg%h", a), expRd(a), v);
    end
    chk("absOvCode", mdl[0], 8'(absOvCode));
    chk("relOvCode", mdl[1], 8'(relOvCode));
    chk("uvCode", mdl[2], 8'(uvCode));
    chk("otCode", mdl[3], 8'(otCode));
    chk("protDisable", mdl[4], 8'(protDisable));
    chk("gainCode", mdl[7], 8'(gainCode));
    chk("faultFlags", 8'(mf), 8'(faultFlags));
    chk("phaseOcFlags", mp, phaseOcFlags);
  endtask

  task automatic doReset;
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[7] = 8'h02;
    mf = '0;
    mp = '0;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    keyValue = 8'h00;
    phaseReportEn = 1'b0;
    faultDetect = '0;
    phaseOcDetect = '0;
    seed = 32'hd3091ca7;
    doReset();
    chkAll();
    // Random writes, lock on about half of them, flag registers included
    for (int i = 0; i < 48; i++) begin
      @(posedge sys_clk);
      keyValue <= ($random(seed) & 1) ? 8'ha6 : 8'($random(seed));
      wrM('h25 + ($random(seed) & 7), 8'($random(seed)));
      chkAll();
    end
    // Detectors with random disable mask, reporting enable off on every third pass
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      faultDetect <= '0;
      phaseOcDetect <= '0;
      keyValue <= 8'h00;
      repeat (3) @(posedge sys_clk);
      wrM('h29, 8'($random(seed)));
      faultDetect <= 5'($random(seed) & $random(seed));
      phaseOcDetect <= 8'($random(seed) & $random(seed) & $random(seed));
      phaseReportEn <= (i % 3 != 2);
      repeat (4) @(posedge sys_clk);
      mf = mf | (faultDetect & ~mdl[4][4:0]);
      mp = phaseReportEn ? (mp | phaseOcDetect) : 8'h00;
      chkAll();
    end
    @(posedge sys_clk);
    faultDetect <= '0;
    phaseOcDetect <= '0;
    repeat (4) @(posedge sys_clk);
    chkAll();
    // Mid-run reset clears flags and settings except gain, which returns to 2
    @(posedge sys_clk);
    doReset();
    chkAll();
    summarize();
  end
endmodule

`default_nettype wire
